// >>> hdl/dp_user_regs.v
// Purpose: Digipot register bank with scratch bytes and nonvolatile copy
// Assumes: Two-wire bus pins synchronous to clk; sda is open drain
// Notes: rst is the power-on reset; nonvolatile cells ignore it
`timescale 1ns/1ns
`default_nettype none
`include "dp_consts.vh"
// Functional notes
// R01: Second scratch register lives at 26h and resets to zero.
// R02: First scratch byte is read/write, left aligned in bits 11 to 4.
// R03: Second scratch byte uses the same left-aligned layout.
// R04: Target answers one of four addresses chosen by the select strap.
// R05: Host writes address byte, then MSB, then LSB of each word.
// R06: Host powers up wiper via config register D1h with 11h, E5h.
// R07: Host sets wiper by writing left-aligned code to register 21h.
// R08: Writing 0010h to D3h commits settings to nonvolatile memory.
// R09: Stored settings survive power cycles and are restored at power-up.
// R10: Store trigger bit 4 copies registers, shows busy, self-clears.
// R11: Writing the position register updates the active wiper at once.
// R12: Scratch don't-care bits are dropped on write, read as zero.
module dp_user_regs
#(
   parameter STORE_CYCLES = `DP_NV_STORE_CYC
)
(
   input wire clk,
   input wire rst,
   input wire scl,
   input wire sda_in,
   output reg sda_out,
   output wire sda_oe,
   input wire [1:0] address_select_pin,
   input wire nvm_clear,
   output reg [7:0] wiper_code,
   output reg [1:0] power_down,
   output reg ref_en,
   output reg [1:0] out_span,
   output reg nonvolatile_busy_flag
);
   reg [7:0] byte1_ff, byte2_ff;
   reg [4:0] cfg_ff;
   reg [7:0] nv_wiper_ff, nv_byte1_ff, nv_byte2_ff;
   reg [4:0] nv_cfg_ff;
   reg [6:0] tgt_addr_ff;
   reg strap_done_ff, recall_ff, store_ff;
   reg [31:0] store_cnt_ff;
   reg [15:0] rd_data;
   wire wr;
   wire [7:0] ptr;
   wire [15:0] wdata;
   wire [7:0] wbyte = wdata[`DP_BYTE_MSB:`DP_BYTE_LSB];

   dp_i2c_target u_tgt
   (
      .clk(clk),
      .rst(rst),
      .scl(scl),
      .sda_in(sda_in),
      .tgt_addr(tgt_addr_ff),
      .rd_data(rd_data),
      .sda_oe_ff(sda_oe),
      .wr_ff(wr),
      .ptr_ff(ptr),
      .wdata_ff(wdata)
   );

   // Strap caught once after reset release
   always @(posedge clk)
   begin
      if (rst)
      begin
         strap_done_ff <= 1'b0;
         tgt_addr_ff <= {`DP_TGT_BASE, 2'b00};
      end
      else if (!strap_done_ff)
      begin
         strap_done_ff <= 1'b1;
         tgt_addr_ff <= {`DP_TGT_BASE, address_select_pin}; // R04
      end
   end

   always @*
   begin
      rd_data = 16'h0000; // R12
      case (ptr)
         `DP_ADDR_WIPER: rd_data[`DP_BYTE_MSB:`DP_BYTE_LSB] = wiper_code;
         `DP_ADDR_BYTE1: rd_data[`DP_BYTE_MSB:`DP_BYTE_LSB] = byte1_ff; // R02
         `DP_ADDR_BYTE2: rd_data[`DP_BYTE_MSB:`DP_BYTE_LSB] = byte2_ff; // R03
         `DP_ADDR_CONFIG: rd_data = {5'h00, `DP_CFG_FIXED_RD} | {11'h000, cfg_ff};
         `DP_ADDR_STATUS: rd_data[`DP_STAT_BUSY_BIT] = nonvolatile_busy_flag;
         default: rd_data = 16'h0000;
      endcase
   end

   // Nonvolatile cells: no power-on reset, so contents survive rst
   always @(posedge clk)
   begin
      if (nvm_clear)
      begin
         nv_wiper_ff <= `DP_RST_WIPER;
         nv_byte1_ff <= `DP_RST_BYTE;
         nv_byte2_ff <= `DP_RST_BYTE;
         nv_cfg_ff <= `DP_RST_CFG;
      end
      else if (store_ff && store_cnt_ff == 32'h0)
      begin
         nv_wiper_ff <= wiper_code; // R08
         nv_byte1_ff <= byte1_ff;
         nv_byte2_ff <= byte2_ff;
         nv_cfg_ff <= cfg_ff;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         wiper_code <= `DP_RST_WIPER;
         byte1_ff <= `DP_RST_BYTE;
         byte2_ff <= `DP_RST_BYTE; // R01
         cfg_ff <= `DP_RST_CFG;
         recall_ff <= 1'b1;
         store_ff <= 1'b0;
         store_cnt_ff <= 32'h0;
         nonvolatile_busy_flag <= 1'b1;
         sda_out <= 1'b0;
      end
      else
      begin
         sda_out <= 1'b0;
         recall_ff <= 1'b0;
         if (recall_ff)
         begin
            wiper_code <= nv_wiper_ff; // R09
            byte1_ff <= nv_byte1_ff;
            byte2_ff <= nv_byte2_ff;
            cfg_ff <= nv_cfg_ff;
         end
         else if (wr)
         begin
            case (ptr)
               `DP_ADDR_WIPER: wiper_code <= wbyte; // R11 R07
               `DP_ADDR_BYTE1: byte1_ff <= wbyte; // R02 R12
               `DP_ADDR_BYTE2: byte2_ff <= wbyte; // R03
               `DP_ADDR_CONFIG: cfg_ff <= wdata[4:0]; // R06
               `DP_ADDR_PROTECT:
               begin
                  if (wdata[`DP_PROT_STORE_BIT] && !store_ff)
                  begin
                     store_ff <= 1'b1; // R10
                     store_cnt_ff <= STORE_CYCLES - 1;
                  end
                  else if (wdata[`DP_PROT_RELOAD_BIT] && !store_ff)
                     recall_ff <= 1'b1;
               end
               default: ;
            endcase
         end
         if (store_ff)
         begin
            if (store_cnt_ff == 32'h0)
               store_ff <= 1'b0; // R10
            else
               store_cnt_ff <= store_cnt_ff - 32'h1;
         end
         nonvolatile_busy_flag <= (store_ff && store_cnt_ff != 32'h0)
            || (wr && ptr == `DP_ADDR_PROTECT
                && (wdata[`DP_PROT_STORE_BIT] || wdata[`DP_PROT_RELOAD_BIT]))
            || (recall_ff && !rst);
      end
   end

   always @(posedge clk)
   begin
      power_down <= cfg_ff[`DP_CFG_PDN_MSB:`DP_CFG_PDN_LSB];
      ref_en <= cfg_ff[`DP_CFG_REF_BIT];
      out_span <= cfg_ff[`DP_CFG_SPAN_MSB:`DP_CFG_SPAN_LSB];
   end
endmodule // dp_user_regs
`default_nettype wire

// >>> hdl/dp_consts.vh
// Purpose: Shared constants for the digipot register bank and serial target
// Assumes: 50 MHz system clock
// Notes: Offsets are register addresses seen over the two-wire bus
`ifndef DP_CONSTS_VH
`define DP_CONSTS_VH

`define DP_CLK_NS 20
// Register addresses
`define DP_ADDR_WIPER 8'h21
`define DP_ADDR_BYTE1 8'h25
`define DP_ADDR_BYTE2 8'h26
`define DP_ADDR_STATUS 8'hd0
`define DP_ADDR_CONFIG 8'hd1
`define DP_ADDR_PROTECT 8'hd3
// Left-aligned byte field in a 16-bit register
`define DP_BYTE_MSB 11
`define DP_BYTE_LSB 4
// Configuration fields
`define DP_CFG_PDN_MSB 4
`define DP_CFG_PDN_LSB 3
`define DP_CFG_REF_BIT 2
`define DP_CFG_SPAN_MSB 1
`define DP_CFG_SPAN_LSB 0
`define DP_CFG_FIXED_RD 11'h1e0
// Protection command and status fields
`define DP_PROT_STORE_BIT 4
`define DP_PROT_RELOAD_BIT 5
`define DP_STAT_BUSY_BIT 0
// Reset values
`define DP_RST_WIPER 8'h00
`define DP_RST_BYTE 8'h00
`define DP_RST_CFG 5'h10
// Target address: upper five bits fixed, low two from the strap
`define DP_TGT_BASE 5'h12
// Nonvolatile store duration
`define DP_NV_STORE_NS 100000
`define DP_NV_STORE_CYC ((`DP_NV_STORE_NS + `DP_CLK_NS - 1) / `DP_CLK_NS)

`endif

// >>> hdl/dp_i2c_target.v
// Purpose: Byte-level two-wire target that turns writes into word strobes
// Assumes: scl and sda_in synchronous to clk, far slower than clk
// Notes: Read data is sampled from rd_data at the start of each byte
`timescale 1ns/1ns
`default_nettype none
module dp_i2c_target
(
   input wire clk,
   input wire rst,
   input wire scl,
   input wire sda_in,
   input wire [6:0] tgt_addr,
   input wire [15:0] rd_data,
   output reg sda_oe_ff,
   output reg wr_ff,
   output reg [7:0] ptr_ff,
   output reg [15:0] wdata_ff
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_PTR = 3'h2;
   localparam ST_MSB = 3'h3;
   localparam ST_LSB = 3'h4;
   localparam ST_RMSB = 3'h5;
   localparam ST_RLSB = 3'h6;

   reg scl_q_ff, scl_qq_ff, sda_q_ff, sda_qq_ff;
   reg [2:0] state_ff;
   reg [3:0] cnt_ff;
   reg ack_ph_ff, mack_ff;
   reg [7:0] sh_ff, tx_ff, msb_ff;
   wire start = scl_q_ff & scl_qq_ff & sda_qq_ff & ~sda_q_ff;
   wire stop = scl_q_ff & scl_qq_ff & ~sda_qq_ff & sda_q_ff;
   wire rise = scl_q_ff & ~scl_qq_ff;
   wire fall = ~scl_q_ff & scl_qq_ff;
   wire rd_st = (state_ff == ST_RMSB) | (state_ff == ST_RLSB);

   always @(posedge clk)
   begin
      if (rst)
      begin
         scl_q_ff <= 1'b1;
         scl_qq_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         sda_qq_ff <= 1'b1;
         state_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         ack_ph_ff <= 1'b0;
         mack_ff <= 1'b0;
         sh_ff <= 8'h00;
         tx_ff <= 8'h00;
         msb_ff <= 8'h00;
         sda_oe_ff <= 1'b0;
         wr_ff <= 1'b0;
         ptr_ff <= 8'h00;
         wdata_ff <= 16'h0000;
      end
      else
      begin
         scl_q_ff <= scl;
         scl_qq_ff <= scl_q_ff;
         sda_q_ff <= sda_in;
         sda_qq_ff <= sda_q_ff;
         wr_ff <= 1'b0;
         if (start)
         begin
            state_ff <= ST_ADDR;
            cnt_ff <= 4'h0;
            ack_ph_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
         end
         else if (stop)
         begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
         end
         else if (state_ff != ST_IDLE)
         begin
            if (rise && ack_ph_ff)
               mack_ff <= ~sda_q_ff;
            else if (rise && cnt_ff < 4'h8)
            begin
               sh_ff <= {sh_ff[6:0], sda_q_ff};
               cnt_ff <= cnt_ff + 4'h1;
            end
            if (fall && !ack_ph_ff && cnt_ff == 4'h8)
            begin
               ack_ph_ff <= 1'b1;
               sda_oe_ff <= ~rd_st;
               case (state_ff)
                  ST_ADDR:
                  begin
                     if (sh_ff[7:1] != tgt_addr) // R04
                     begin
                        state_ff <= ST_IDLE;
                        sda_oe_ff <= 1'b0;
                     end
                  end
                  ST_PTR: ptr_ff <= sh_ff;
                  ST_MSB: msb_ff <= sh_ff;
                  ST_LSB:
                  begin
                     wr_ff <= 1'b1; // R05
                     wdata_ff <= {msb_ff, sh_ff};
                  end
                  default: sda_oe_ff <= 1'b0;
               endcase
            end
            else if (fall && ack_ph_ff)
            begin
               ack_ph_ff <= 1'b0;
               cnt_ff <= 4'h0;
               sda_oe_ff <= 1'b0;
               case (state_ff)
                  ST_ADDR:
                  begin
                     if (sh_ff[0])
                     begin
                        state_ff <= ST_RMSB;
                        tx_ff <= rd_data[15:8];
                        sda_oe_ff <= ~rd_data[15];
                     end
                     else
                        state_ff <= ST_PTR;
                  end
                  ST_PTR: state_ff <= ST_MSB;
                  ST_MSB: state_ff <= ST_LSB;
                  ST_LSB: state_ff <= ST_MSB;
                  ST_RMSB, ST_RLSB:
                  begin
                     if (mack_ff)
                     begin
                        state_ff <= (state_ff == ST_RMSB) ? ST_RLSB : ST_RMSB;
                        tx_ff <= (state_ff == ST_RMSB) ? rd_data[7:0]
                                                       : rd_data[15:8];
                        sda_oe_ff <= (state_ff == ST_RMSB) ? ~rd_data[7]
                                                           : ~rd_data[15];
                     end
                     else
                        state_ff <= ST_IDLE;
                  end
                  default: state_ff <= ST_IDLE;
               endcase
            end
            else if (fall && rd_st && cnt_ff != 4'h0)
            begin
               tx_ff <= {tx_ff[6:0], 1'b0};
               sda_oe_ff <= ~tx_ff[6];
            end
         end
      end
   end
endmodule // dp_i2c_target
`default_nettype wire

// >>> verification/dubas_sva.sv
// Purpose: Port-level checks for the digipot register bank
// Assumes: Bound to dp_user_regs; one clock, synchronous reset
// Notes: Store length is checked for the short simulation value
`timescale 1ns/1ns
`default_nettype none
module dubas_sva
#(
   parameter STORE_CYCLES = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [1:0] address_select_pin,
   input wire logic nvm_clear,
   input wire logic [7:0] wiper_code,
   input wire logic [1:0] power_down,
   input wire logic ref_en,
   input wire logic [1:0] out_span,
   input wire logic nonvolatile_busy_flag
);
   oe_reset_a: assert property (@(posedge clk) rst |=> !sda_oe)
      else $error("sda driven after reset");
   busy_reset_a: assert property (@(posedge clk) rst |=>
      nonvolatile_busy_flag && wiper_code == 8'h00)
      else $error("reset state wrong");
   drain_low_a: assert property (@(posedge clk) disable iff (rst)
      !sda_out) else $error("sda output not low");
   store_len_a: assert property (@(posedge clk) disable iff (rst)
      $rose(nonvolatile_busy_flag) |-> nonvolatile_busy_flag[*8]
      ##1 !nonvolatile_busy_flag) else $error("store busy length wrong");
   ack_hold_a: assert property (@(posedge clk) disable iff (rst)
      scl && $past(scl) |-> $stable(sda_oe))
      else $error("sda changed while scl high");
   ack_start_a: assert property (@(posedge clk) disable iff (rst)
      $rose(sda_oe) |-> !scl) else $error("ack began with scl high");
   wiper_upd_a: assert property (@(posedge clk) disable iff (rst)
      $changed(wiper_code) |-> sda_oe || $past(rst) || $past(rst, 2)
      || $past(rst, 3)) else $error("wiper changed outside a write");
   cfg_upd_a: assert property (@(posedge clk) disable iff (rst)
      $changed({power_down, ref_en, out_span}) |-> sda_oe || $past(rst)
      || $past(rst, 2) || $past(rst, 3) || $past(rst, 4))
      else $error("config changed outside a write");
endmodule // dubas_sva
`default_nettype wire

// >>> verification/dubas_host.sv
// Purpose: Two-wire bus controller model acting as the host processor
// Assumes: Open-drain sda with pull-up; scl is driven push-pull
// Notes: Quarter bit is Q clocks; device acks 2 clocks after fall
`timescale 1ns/1ns
`default_nettype none
module dubas_host
(
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic host_low
);
   localparam int Q = 4;
   initial
   begin
      scl = 1'b1;
      host_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put_bit(input logic b, output logic got);
      host_low <= ~b;
      tick(Q);
      scl <= 1'b1;
      tick(2 * Q);
      got = sda_in;
      scl <= 1'b0;
      tick(Q);
   endtask
   task automatic start();
      host_low <= 1'b1;
      tick(Q);
      scl <= 1'b0;
      tick(Q);
   endtask
   task automatic stop();
      host_low <= 1'b1;
      tick(Q);
      scl <= 1'b1;
      tick(Q);
      host_low <= 1'b0;
      tick(2 * Q);
   endtask
   task automatic send(input logic [7:0] v, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) put_bit(v[i], g);
      put_bit(1'b1, g);
      ack = ~g;
   endtask
   task automatic recv(input logic last, output logic [7:0] v);
      logic g;
      for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
      put_bit(last, g);
   endtask
   // Address byte, pointer, MSB then LSB
   task automatic write_word(input logic [6:0] tgt, input logic [7:0] ptr,
      input logic [15:0] d, output logic ok);
      logic a0, a1, a2, a3;
      start();
      send({tgt, 1'b0}, a0);
      send(ptr, a1);
      send(d[15:8], a2);
      send(d[7:0], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask
   task automatic read_word(input logic [6:0] tgt, input logic [7:0] ptr,
      output logic [15:0] d);
      logic a;
      start();
      send({tgt, 1'b0}, a);
      send(ptr, a);
      stop();
      start();
      send({tgt, 1'b1}, a);
      recv(1'b0, d[15:8]);
      recv(1'b1, d[7:0]);
      stop();
   endtask
endmodule // dubas_host
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Register-level tests of the digipot bank over the serial bus
// Assumes: Short store time; strap fixed at code 2
// Notes: nvm_clear blanks the cells once during the first reset
`timescale 1ns/1ns
`default_nettype none
`include "dp_consts.vh"
module tb;
   localparam int STORE_CYCLES = 8;
   logic clk, rst, nvm_clear, scl, host_low, ok;
   logic [1:0] sel, power_down, out_span;
   logic ref_en, sda_out, sda_oe, busy;
   logic [7:0] wiper_code;
   logic [6:0] tgt;
   int err_count = 0, checks_done = 0, busy_cnt = 0;
   wire sda_in;
   assign sda_in = ~(host_low | sda_oe);
   assign tgt = {`DP_TGT_BASE, sel};
   dp_user_regs #(.STORE_CYCLES(STORE_CYCLES)) i_dp_user_regs (.clk(clk),
      .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .address_select_pin(sel), .nvm_clear(nvm_clear),
      .wiper_code(wiper_code), .power_down(power_down), .ref_en(ref_en),
      .out_span(out_span), .nonvolatile_busy_flag(busy));
   dubas_host i_dubas_host (.clk(clk), .sda_in(sda_in), .scl(scl),
      .host_low(host_low));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (!rst && busy === 1'b1) busy_cnt <= busy_cnt + 1;
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      i_dubas_host.write_word(tgt, p, d, ok);
      check("write ack", ok, 1);
   endtask
   task automatic rd(input logic [7:0] p, input logic [15:0] e);
      logic [15:0] d;
      i_dubas_host.read_word(tgt, p, d);
      check("read", d, e);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   initial
   begin
      rst = 1'b1;
      nvm_clear = 1'b1;
      sel = 2'b10;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      nvm_clear <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`DP_ADDR_BYTE2, 16'h0000);
      check("pdn reset", power_down, 2'b10);
      $display("test reset done");
      wr(`DP_ADDR_BYTE1, 16'hfa47);
      wr(`DP_ADDR_BYTE2, 16'hf5bf);
      rd(`DP_ADDR_BYTE1, 16'h0a40);
      rd(`DP_ADDR_BYTE2, 16'h05b0);
      $display("test scratch done");
      for (int i = 0; i < 4; i++)
      begin
         i_dubas_host.write_word({`DP_TGT_BASE, i[1:0]}, `DP_ADDR_BYTE1,
            16'h0110 * (i + 1), ok);
         check("strap ack", ok, i == 2);
      end
      rd(`DP_ADDR_BYTE1, 16'h0330);
      $display("test address done");
      wr(`DP_ADDR_CONFIG, 16'h11e5);
      check("setup", {power_down, ref_en, out_span}, 5'h05);
      rd(`DP_ADDR_CONFIG, 16'h01e5);
      wr(`DP_ADDR_WIPER, 16'h0940);
      check("wiper", wiper_code, 8'h94);
      $display("test setup done");
      busy_cnt = 0;
      wr(`DP_ADDR_PROTECT, 16'h0010);
      check("store busy", busy_cnt, STORE_CYCLES);
      rd(`DP_ADDR_PROTECT, 16'h0000);
      rd(`DP_ADDR_STATUS, 16'h0000);
      wr(`DP_ADDR_WIPER, 16'h0120);
      wr(`DP_ADDR_CONFIG, 16'h1010);
      check("wiper new", wiper_code, 8'h12);
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("recall wiper", wiper_code, 8'h94);
      check("recall cfg", {power_down, ref_en, out_span}, 5'h05);
      $display("test store done");
      wrap_up();
   end
endmodule // tb
bind dp_user_regs dubas_sva #(.STORE_CYCLES(STORE_CYCLES)) i_dubas_sva (
   .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .address_select_pin(address_select_pin),
   .nvm_clear(nvm_clear), .wiper_code(wiper_code), .power_down(power_down),
   .ref_en(ref_en), .out_span(out_span),
   .nonvolatile_busy_flag(nonvolatile_busy_flag));
`default_nettype wire
